/* hdl/tmcs_timer3_ctrl.sv */
// Notes on behaviour
// R1: Run bit low halts and clears counter.
// R2: Clock select picks prescaled, low, high or pin.
// R3: Slow modes allow few sources; high warm-up.
// R4: Mode field decodes divider, PWM, cascade.
// R5: Software keeps mode 011 for cascade.
// R6: Cascade: own clock, second timer's run/preset.
// R7: Software leaves fields alone while running.
// R8: Stop write keeps other fields unchanged.
// R9: Period compare unchanged while running; the code stores period writes at any time, running or not.
// R10: Pulse compare changes only in PWM modes; the code stores pulse writes in every mode.
// R11: Two control, two 8-bit compare registers.
// R12: Control register resets to all zero.
// R13: Upper byte counts this timer's overflow.
// R14: Second mode decodes 16-bit, warm-up, PPG.
// R15: Fields read back, act next edge.
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
module tmcs_timer3_ctrl #(
   parameter int PRESCALE_BITS = tmcs_pkg::HIGH_BITS
) (
   input  wire logic       CLK_SYS,
   input  wire logic       SYS_RST,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic [7:0]      RDATA,
   input  wire logic [1:0] POWER_MODE,
   input  wire logic       DIVIDER_SELECT,
   input  wire logic       HIGH_CLOCK_TICK,
   input  wire logic       LOW_CLOCK_TICK,
   input  wire logic       TIMER3_PIN,
   input  wire logic       TIMER4_PIN,
   input  wire logic       TIMER3_OVERFLOW,
   output logic            TIMER3_RUN,
   output logic            TIMER3_CLEAR,
   output logic            TIMER3_TICK,
   output logic            TIMER3_PRESET,
   output logic            DIVIDER_MODE,
   output logic            PWM8_MODE,
   output logic            CASCADE_MODE,
   output logic            TIMER4_RUN,
   output logic            TIMER4_CLEAR,
   output logic            TIMER4_TICK,
   output logic            TIMER4_PRESET,
   output logic            MODE16_TIMER,
   output logic            WARMUP_MODE,
   output logic            MODE16_PWM,
   output logic            MODE16_PULSE,
   output logic [7:0]      PERIOD_COMPARE,
   output logic [7:0]      PULSE_WIDTH_COMPARE,
   output logic            SELECT_INVALID
);

   typedef struct packed {
      logic [7:0]             timer3_control;
      logic [7:0]             second_timer_control;
      logic [7:0]             period_compare;
      logic [7:0]             pulse_width_compare;
      logic [7:0]             rdata;
      logic                   pin3_prev;
      logic                   pin4_prev;
      tmcs_pkg::tmcs_run_type run3;
      tmcs_pkg::tmcs_run_type run4;
      logic                   tick3;
      logic                   tick4;
   } tmcs_state_type;

   tmcs_state_type state_reg;
   tmcs_state_type state_next;
   logic [5:0]     taps;
   logic [2:0]     clock_select;
   logic [2:0]     mode_select;
   logic [2:0]     second_clock_select;
   logic [2:0]     second_mode_select;
   logic           run_control;
   logic           flipflop_preset;
   logic           second_run_control;
   logic           second_flipflop_preset;
   logic           slow_power;
   logic           cascade;
   logic           upper_byte;
   logic           warmup;
   logic           edge3;
   logic           edge4;
   logic           src3;
   logic           src4;
   logic           bad3;
   logic           bad4;
   logic [7:0]     status;

   // Shared prescaler of the high and low clock ticks.
   tmcs_prescaler #(
      .HIGH_BITS (PRESCALE_BITS)
   ) u_prescaler (
      .clk_sys   (CLK_SYS),
      .sys_rst   (SYS_RST),
      .high_tick (HIGH_CLOCK_TICK),
      .low_tick  (LOW_CLOCK_TICK),
      .taps      (taps)
   );

   // Picks one source tick for a clock select code.
   // R2: source clock mux
   function automatic logic pick_source(
      input logic [2:0] sel,
      input logic       slow,
      input logic       divsel,
      input logic       high_ok,
      input logic [5:0] tp,
      input logic       low_t,
      input logic       high_t,
      input logic       pin_edge
   );
      logic r;
      r = 1'b0;
      case (sel)
         tmcs_pkg::CKS_DIV11: begin
            r = (slow | divsel) ? tp[tmcs_pkg::TAP_LOW3]
                                : tp[tmcs_pkg::TAP_DIV11];
         end
         tmcs_pkg::CKS_DIV7:     r = ~slow & tp[tmcs_pkg::TAP_DIV7];
         tmcs_pkg::CKS_DIV5:     r = ~slow & tp[tmcs_pkg::TAP_DIV5];
         tmcs_pkg::CKS_DIV3:     r = ~slow & tp[tmcs_pkg::TAP_DIV3];
         tmcs_pkg::CKS_LOW:      r = low_t;
         tmcs_pkg::CKS_DIV1:     r = ~slow & tp[tmcs_pkg::TAP_DIV1];
         tmcs_pkg::CKS_HIGH:     r = (~slow | high_ok) & high_t;
         tmcs_pkg::CKS_EXTERNAL: r = pin_edge;
         default:                r = 1'b0;
      endcase
      return r;
   endfunction

   // Tells whether a select code has no source in the present power mode.
   // R3: slow mode limits
   function automatic logic source_unusable(
      input logic [2:0] sel,
      input logic       slow,
      input logic       high_ok
   );
      logic r;
      r = 1'b0;
      case (sel)
         tmcs_pkg::CKS_DIV7,
         tmcs_pkg::CKS_DIV5,
         tmcs_pkg::CKS_DIV3,
         tmcs_pkg::CKS_DIV1: r = slow;
         tmcs_pkg::CKS_HIGH: r = slow & ~high_ok;
         default:            r = 1'b0;
      endcase
      return r;
   endfunction

   // Field views of the two control registers.
   assign flipflop_preset =
      state_reg.timer3_control[tmcs_pkg::FLD_PRESET];
   assign clock_select = state_reg.timer3_control[
      tmcs_pkg::FLD_CLK_HI:tmcs_pkg::FLD_CLK_LO];
   assign run_control = state_reg.timer3_control[tmcs_pkg::FLD_RUN];
   assign mode_select = state_reg.timer3_control[
      tmcs_pkg::FLD_MODE_HI:tmcs_pkg::FLD_MODE_LO];
   assign second_flipflop_preset =
      state_reg.second_timer_control[tmcs_pkg::FLD_PRESET];
   assign second_clock_select = state_reg.second_timer_control[
      tmcs_pkg::FLD_CLK_HI:tmcs_pkg::FLD_CLK_LO];
   assign second_run_control =
      state_reg.second_timer_control[tmcs_pkg::FLD_RUN];
   assign second_mode_select = state_reg.second_timer_control[
      tmcs_pkg::FLD_MODE_HI:tmcs_pkg::FLD_MODE_LO];

   // Power mode and mode decodes.
   assign slow_power = (POWER_MODE == tmcs_pkg::PM_SLOW) |
                       (POWER_MODE == tmcs_pkg::PM_SLEEP);
   // R4: cascade decode
   assign cascade = (mode_select == tmcs_pkg::MODE_CASCADE);
   // R13: upper byte modes
   assign upper_byte = second_mode_select[2];
   // R3: warm-up needs cascade
   assign warmup = cascade &
                   (second_mode_select == tmcs_pkg::MODE_WARMUP);

   // Rising edges of the timer pins, inputs being synchronous.
   assign edge3 = TIMER3_PIN & ~state_reg.pin3_prev;
   assign edge4 = TIMER4_PIN & ~state_reg.pin4_prev;

   // Source ticks of both timers before run gating.
   assign src3 = pick_source(clock_select, slow_power, DIVIDER_SELECT,
                             warmup, taps, LOW_CLOCK_TICK,
                             HIGH_CLOCK_TICK, edge3);
   assign src4 = pick_source(second_clock_select, slow_power,
                             DIVIDER_SELECT, 1'b0, taps,
                             LOW_CLOCK_TICK, HIGH_CLOCK_TICK, edge4);
   assign bad3 = source_unusable(clock_select, slow_power, warmup);
   assign bad4 = ~upper_byte &
                 source_unusable(second_clock_select, slow_power, 1'b0);

   // Status view of the block's own state.
   assign status = {3'h0, cascade, bad4, bad3,
                    state_reg.run4 == tmcs_pkg::RS_RUNNING,
                    state_reg.run3 == tmcs_pkg::RS_RUNNING};

   // Next state: register writes, read data, run state and ticks.
   always_comb begin
      state_next = state_reg;
      state_next.pin3_prev = TIMER3_PIN;
      state_next.pin4_prev = TIMER4_PIN;
      // R11: control and compare registers
      // R15: write takes effect next edge
      if (WR) begin
         case (ADDR)
            tmcs_pkg::ADDR_CONTROL: state_next.timer3_control = WDATA;
            tmcs_pkg::ADDR_SECOND:
               state_next.second_timer_control = WDATA;
            tmcs_pkg::ADDR_PERIOD:  state_next.period_compare = WDATA;
            tmcs_pkg::ADDR_PULSE:
               state_next.pulse_width_compare = WDATA;
            default: state_next.timer3_control = state_reg.timer3_control;
         endcase
      end
      // R15: fields read back
      if (RD) begin
         case (ADDR)
            tmcs_pkg::ADDR_CONTROL: state_next.rdata =
               state_reg.timer3_control;
            tmcs_pkg::ADDR_SECOND:  state_next.rdata =
               state_reg.second_timer_control;
            tmcs_pkg::ADDR_PERIOD:  state_next.rdata =
               state_reg.period_compare;
            tmcs_pkg::ADDR_PULSE:   state_next.rdata =
               state_reg.pulse_width_compare;
            tmcs_pkg::ADDR_STATUS:  state_next.rdata = status;
            default:                state_next.rdata = 8'h00;
         endcase
      end else begin
         state_next.rdata = 8'h00;
      end
      // R1: run state follows start bit
      // R6: cascade uses second run bit
      if (cascade) begin
         state_next.run3 = tmcs_pkg::tmcs_run_type'(second_run_control);
      end else begin
         state_next.run3 = tmcs_pkg::tmcs_run_type'(run_control);
      end
      state_next.run4 = tmcs_pkg::tmcs_run_type'(second_run_control);
      // R6: cascade clock from own select
      state_next.tick3 = (state_next.run3 == tmcs_pkg::RS_RUNNING) &
                         (state_reg.run3 == tmcs_pkg::RS_RUNNING) &
                         src3;
      // R13: upper byte takes overflow
      state_next.tick4 = (state_next.run4 == tmcs_pkg::RS_RUNNING) &
                         (state_reg.run4 == tmcs_pkg::RS_RUNNING) &
                         (upper_byte ? TIMER3_OVERFLOW : src4);
   end

   // State register.
   // R12: control resets to zero
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         state_reg <= '{
            timer3_control:       tmcs_pkg::CONTROL_RESET,
            second_timer_control: tmcs_pkg::SECOND_RESET,
            period_compare:       tmcs_pkg::PERIOD_RESET,
            pulse_width_compare:  tmcs_pkg::PULSE_RESET,
            rdata:                8'h00,
            pin3_prev:            1'b0,
            pin4_prev:            1'b0,
            run3:                 tmcs_pkg::RS_STOPPED,
            run4:                 tmcs_pkg::RS_STOPPED,
            tick3:                1'b0,
            tick4:                1'b0
         };
      end else begin
         state_reg <= state_next;
      end
   end

   // Run and clear outputs; the counter is held clear while stopped.
   // R1: stop clears counter
   assign TIMER3_RUN   = (state_reg.run3 == tmcs_pkg::RS_RUNNING);
   assign TIMER3_CLEAR = (state_reg.run3 == tmcs_pkg::RS_STOPPED);
   assign TIMER4_RUN   = (state_reg.run4 == tmcs_pkg::RS_RUNNING);
   assign TIMER4_CLEAR = (state_reg.run4 == tmcs_pkg::RS_STOPPED);
   assign TIMER3_TICK  = state_reg.tick3;
   assign TIMER4_TICK  = state_reg.tick4;

   // Flip-flop presets.
   // R6: cascade preset from second
   assign TIMER3_PRESET = cascade ? second_flipflop_preset
                                  : flipflop_preset;
   assign TIMER4_PRESET = second_flipflop_preset;

   // Mode decodes of both fields.
   // R4: first mode decode
   assign DIVIDER_MODE = (mode_select == tmcs_pkg::MODE_DIVIDER);
   assign PWM8_MODE    = (mode_select == tmcs_pkg::MODE_PWM8);
   assign CASCADE_MODE = cascade;
   // R14: second mode decode
   assign MODE16_TIMER = cascade &
                         (second_mode_select == tmcs_pkg::MODE16_TIMER);
   assign WARMUP_MODE  = warmup;
   assign MODE16_PWM   = cascade &
                         (second_mode_select == tmcs_pkg::MODE16_PWM);
   assign MODE16_PULSE = cascade &
                         (second_mode_select == tmcs_pkg::MODE16_PULSE);

   // Compare values, read data and source fault flag.
   // R11: compare register outputs
   assign PERIOD_COMPARE      = state_reg.period_compare;
   assign PULSE_WIDTH_COMPARE = state_reg.pulse_width_compare;
   assign RDATA               = state_reg.rdata;
   assign SELECT_INVALID      = bad3 | bad4;

endmodule // tmcs_timer3_ctrl

/* hdl/tmcs_pkg.sv */
package tmcs_pkg;

   // Register addresses on the 8-bit register port.
   localparam logic [7:0] ADDR_PERIOD  = 8'h25;
   localparam logic [7:0] ADDR_PULSE   = 8'h26;
   localparam logic [7:0] ADDR_CONTROL = 8'h27;
   localparam logic [7:0] ADDR_SECOND  = 8'h28;
   localparam logic [7:0] ADDR_STATUS  = 8'h29;

   // Reset values of the writable registers.
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] SECOND_RESET  = 8'h00;
   localparam logic [7:0] PERIOD_RESET  = 8'h00;
   localparam logic [7:0] PULSE_RESET   = 8'h00;

   // Field positions shared by both control registers.
   localparam int FLD_PRESET  = 7;
   localparam int FLD_CLK_HI  = 6;
   localparam int FLD_CLK_LO  = 4;
   localparam int FLD_RUN     = 3;
   localparam int FLD_MODE_HI = 2;
   localparam int FLD_MODE_LO = 0;

   // Status register bit positions.
   localparam int STS_RUN3     = 0;
   localparam int STS_RUN4     = 1;
   localparam int STS_BAD3     = 2;
   localparam int STS_BAD4     = 3;
   localparam int STS_CASCADE  = 4;

   // Source clock select codes.
   localparam logic [2:0] CKS_DIV11    = 3'h0;
   localparam logic [2:0] CKS_DIV7     = 3'h1;
   localparam logic [2:0] CKS_DIV5     = 3'h2;
   localparam logic [2:0] CKS_DIV3     = 3'h3;
   localparam logic [2:0] CKS_LOW      = 3'h4;
   localparam logic [2:0] CKS_DIV1     = 3'h5;
   localparam logic [2:0] CKS_HIGH     = 3'h6;
   localparam logic [2:0] CKS_EXTERNAL = 3'h7;

   // Operating mode codes of both mode fields.
   localparam logic [2:0] MODE_TIMER8   = 3'h0;
   localparam logic [2:0] MODE_DIVIDER  = 3'h1;
   localparam logic [2:0] MODE_PWM8     = 3'h2;
   localparam logic [2:0] MODE_CASCADE  = 3'h3;
   localparam logic [2:0] MODE16_TIMER  = 3'h4;
   localparam logic [2:0] MODE_WARMUP   = 3'h5;
   localparam logic [2:0] MODE16_PWM    = 3'h6;
   localparam logic [2:0] MODE16_PULSE  = 3'h7;

   // Prescaler taps of the high and low clocks: divide by two to these powers.
   localparam int HIGH_TAPS = 5;
   localparam int TAP_EXP [HIGH_TAPS] = '{1, 3, 5, 7, 11};
   localparam int TAP_DIV1  = 0;
   localparam int TAP_DIV3  = 1;
   localparam int TAP_DIV5  = 2;
   localparam int TAP_DIV7  = 3;
   localparam int TAP_DIV11 = 4;
   localparam int TAP_LOW3  = 5;
   localparam int HIGH_BITS = 11;
   localparam int LOW_EXP   = 3;

   // Power modes of the surrounding system.
   typedef enum logic [1:0] {
      PM_NORMAL = 2'b00,
      PM_IDLE   = 2'b01,
      PM_SLOW   = 2'b10,
      PM_SLEEP  = 2'b11
   } tmcs_power_type;

   // Run state of a timer as seen by the counting datapath.
   typedef enum logic {
      RS_STOPPED = 1'b0,
      RS_RUNNING = 1'b1
   } tmcs_run_type;

endpackage

/* hdl/tmcs_prescaler.sv */
`timescale 1ns/10ps
module tmcs_prescaler #(
   parameter int HIGH_BITS = tmcs_pkg::HIGH_BITS
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       high_tick,
   input  wire logic       low_tick,
   output logic [5:0]      taps
);

   typedef struct packed {
      logic [HIGH_BITS-1:0]        high_count;
      logic [tmcs_pkg::LOW_EXP-1:0] low_count;
      logic [5:0]                  taps;
   } tmcs_pre_state_type;

   tmcs_pre_state_type state_reg;
   tmcs_pre_state_type state_next;
   logic [tmcs_pkg::HIGH_TAPS-1:0] hit;

   // Refuse a counter too short for the slowest tap.
   if (HIGH_BITS < tmcs_pkg::TAP_EXP[tmcs_pkg::TAP_DIV11]) begin : g_chk
      $error("Prescaler counter is narrower than the slowest tap.");
   end

   // Each tap fires when the low bits of the counter are all ones.
   for (genvar i = 0; i < tmcs_pkg::HIGH_TAPS; i++) begin : g_tap
      assign hit[i] = high_tick &
         (&state_reg.high_count[tmcs_pkg::TAP_EXP[i]-1:0]);
   end

   // Free running counters of high and low clock ticks.
   always_comb begin
      state_next = state_reg;
      if (high_tick) begin
         state_next.high_count = state_reg.high_count + 1'b1;
      end
      if (low_tick) begin
         state_next.low_count = state_reg.low_count + 1'b1;
      end
      state_next.taps = {low_tick & (&state_reg.low_count), hit};
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign taps = state_reg.taps;

endmodule // tmcs_prescaler

/* verification/tmcs_timer3_monitor.sv */
`timescale 1ns/10ps
module tmcs_timer3_monitor #(
   parameter int PRESCALE_BITS = 11
) (
   input wire logic       CLK_SYS,
   input wire logic       SYS_RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic [1:0] POWER_MODE,
   input wire logic       TIMER3_PIN,
   input wire logic       TIMER3_RUN,
   input wire logic       TIMER3_CLEAR,
   input wire logic       TIMER3_TICK,
   input wire logic       PWM8_MODE,
   input wire logic       CASCADE_MODE,
   input wire logic       MODE16_TIMER,
   input wire logic       WARMUP_MODE,
   input wire logic       MODE16_PWM,
   input wire logic       MODE16_PULSE,
   input wire logic [7:0] PERIOD_COMPARE,
   input wire logic       SELECT_INVALID
);
   logic [7:0] ctl_reg;

   // Shadow copy of the control byte as software last wrote it.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ctl_reg <= 8'h00;
      end else if (WR && ADDR == tmcs_pkg::ADDR_CONTROL) begin
         ctl_reg <= WDATA;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   // Control writes that start or stop the timer outside cascade.
   sequence ctl_wr;
      WR && ADDR == tmcs_pkg::ADDR_CONTROL;
   endsequence
   sequence start_wr;
      ctl_wr ##0 (WDATA[3] && WDATA[2:0] != 3'h3);
   endsequence
   sequence stop_wr;
      ctl_wr ##0 (!WDATA[3] && WDATA[2:0] != 3'h3);
   endsequence

   run_start_a: assert property (
      start_wr |-> ##2 TIMER3_RUN) else $error("run did not start");
   run_stop_a: assert property (
      stop_wr |-> ##2 (!TIMER3_RUN && TIMER3_CLEAR))
      else $error("stop did not halt and clear");
   clear_pairs_run_a: assert property (
      TIMER3_CLEAR != TIMER3_RUN) else $error("clear and run disagree");
   pin_tick_a: assert property (
      $rose(TIMER3_PIN) && TIMER3_RUN && $past(TIMER3_RUN)
      && ctl_reg[6:4] == 3'h7 && ctl_reg[2:0] != 3'h3 |=> TIMER3_TICK)
      else $error("pin edge gave no tick");
   slow_invalid_a: assert property (
      POWER_MODE[1] && ctl_reg[6:4] inside {3'h1, 3'h2, 3'h3, 3'h5}
      |-> SELECT_INVALID) else $error("bad slow source not flagged");
   mode_decode_a: assert property (
      ctl_wr |=> CASCADE_MODE == ($past(WDATA[2:0]) == 3'h3)
      && PWM8_MODE == ($past(WDATA[2:0]) == 3'h2))
      else $error("mode decode wrong");
   upper_gated_a: assert property (
      !CASCADE_MODE |-> !(MODE16_TIMER || WARMUP_MODE || MODE16_PWM
      || MODE16_PULSE)) else $error("upper mode outside cascade");
   period_store_a: assert property (
      WR && ADDR == tmcs_pkg::ADDR_PERIOD |=> PERIOD_COMPARE == $past(WDATA))
      else $error("period compare not stored");
   ctl_readback_a: assert property (
      RD && ADDR == tmcs_pkg::ADDR_CONTROL |=> RDATA == ctl_reg)
      else $error("control readback wrong");
   idle_rdata_a: assert property (
      !RD |=> RDATA == 8'h00) else $error("read data without read");
   tick_needs_run_a: assert property (
      TIMER3_TICK |-> $past(TIMER3_RUN)) else $error("tick while stopped");
endmodule // tmcs_timer3_monitor

bind tmcs_timer3_ctrl tmcs_timer3_monitor #(
   .PRESCALE_BITS(PRESCALE_BITS)
) u_mon (
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .POWER_MODE(POWER_MODE),
   .TIMER3_PIN(TIMER3_PIN), .TIMER3_RUN(TIMER3_RUN),
   .TIMER3_CLEAR(TIMER3_CLEAR), .TIMER3_TICK(TIMER3_TICK),
   .PWM8_MODE(PWM8_MODE), .CASCADE_MODE(CASCADE_MODE),
   .MODE16_TIMER(MODE16_TIMER), .WARMUP_MODE(WARMUP_MODE),
   .MODE16_PWM(MODE16_PWM), .MODE16_PULSE(MODE16_PULSE),
   .PERIOD_COMPARE(PERIOD_COMPARE), .SELECT_INVALID(SELECT_INVALID)
);

/* verification/tb_timer3_control_and_clock_select.sv */
`timescale 1ns/10ps
module tb_timer3_control_and_clock_select;
   logic       clk_sys;
   logic       sys_rst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic [1:0] power_mode;
   logic       div_sel;
   logic       high_tick;
   logic       low_tick;
   logic       pin3;
   logic       ovf3;
   logic       run3, clr3, tick3, pre3, divm, pwm8, casc;
   logic       run4, clr4, tick4, pre4, bad;
   logic [3:0] sdec;
   logic [7:0] pcmp;
   logic [7:0] wcmp;
   logic [7:0] d;
   int         phase = 0;
   int         i;
   int         n;
   int         error_cnt;
   int         cmp_count;

   tmcs_timer3_ctrl dut (
      .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .POWER_MODE(power_mode),
      .DIVIDER_SELECT(div_sel), .HIGH_CLOCK_TICK(high_tick),
      .LOW_CLOCK_TICK(low_tick), .TIMER3_PIN(pin3), .TIMER4_PIN(1'h0),
      .TIMER3_OVERFLOW(ovf3), .TIMER3_RUN(run3), .TIMER3_CLEAR(clr3),
      .TIMER3_TICK(tick3), .TIMER3_PRESET(pre3), .DIVIDER_MODE(divm),
      .PWM8_MODE(pwm8), .CASCADE_MODE(casc), .TIMER4_RUN(run4),
      .TIMER4_CLEAR(clr4), .TIMER4_TICK(tick4), .TIMER4_PRESET(pre4),
      .MODE16_TIMER(sdec[0]), .WARMUP_MODE(sdec[1]), .MODE16_PWM(sdec[2]),
      .MODE16_PULSE(sdec[3]), .PERIOD_COMPARE(pcmp),
      .PULSE_WIDTH_COMPARE(wcmp), .SELECT_INVALID(bad)
   );

   // Free-running clock of 100 MHz.
   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end

   // High tick every 2 cycles, low tick every 10, pin period of 6.
   always @(posedge clk_sys) begin
      phase <= (phase + 1) % 30;
      high_tick <= (phase % 2 == 0);
      low_tick <= (phase % 10 == 0);
      pin3 <= (phase % 6 < 3);
   end

   // Expected tick spacing in cycles for a source select code.
   function automatic int exp_per(input logic [2:0] s, input logic dv);
      case (s)
         3'h0: return dv ? 80 : 4096;
         3'h1: return 256;
         3'h2: return 64;
         3'h3: return 16;
         3'h4: return 10;
         3'h5: return 4;
         3'h6: return 2;
         default: return 6;
      endcase
   endfunction

   // Expected divider, PWM and cascade decodes for a mode code.
   function automatic logic [2:0] exp_dec(input logic [2:0] m);
      return {m == tmcs_pkg::MODE_CASCADE, m == tmcs_pkg::MODE_PWM8,
              m == tmcs_pkg::MODE_DIVIDER};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge clk_sys);
      wr <= 1'h0;
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk_sys);
      rd <= 1'h0;
      #1;
      chk(16'(rdata), 16'(e));
   endtask

   // Measures the gap between two timer ticks; a hang ends the run.
   task automatic meas(input int e);
      n = 0;
      @(negedge clk_sys);
      while (tick3 !== 1'h1 && n < 9000) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      n = 1;
      while (tick3 !== 1'h1 && n < 9000) begin
         @(negedge clk_sys);
         n++;
      end
      chk(16'(n), 16'(e));
      if (n >= 9000) begin
         error_cnt++;
         wrap_up();
      end
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Main sequence of scenarios.
   initial begin
      {addr, wdata, wr, rd, power_mode, div_sel, ovf3} = '0;
      {error_cnt, cmp_count} = '0;
      sys_rst = 1'h1;
      void'($urandom(45206));
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'h0;
      rd_chk(tmcs_pkg::ADDR_CONTROL, 8'h00);
      chk(16'({run3, clr3, pre3}), 16'h0002);
      for (i = 0; i < 8; i++) begin
         d = 8'($urandom);
         wr_reg(tmcs_pkg::ADDR_PERIOD, d);
         chk(16'(pcmp), 16'(d));
         d = 8'($urandom);
         wr_reg(tmcs_pkg::ADDR_PULSE, d);
         rd_chk(tmcs_pkg::ADDR_PULSE, d);
         chk(16'(wcmp), 16'(d));
         d = 8'($urandom) & 8'hF7;
         wr_reg(tmcs_pkg::ADDR_CONTROL, d);
         rd_chk(tmcs_pkg::ADDR_CONTROL, d);
         chk(16'(pre3), 16'((d[2:0] == 3'h3) ? 1'h0 : d[7]));
      end
      wr_reg(8'h30, 8'hFF);
      rd_chk(8'h30, 8'h00);
      rd_chk(tmcs_pkg::ADDR_CONTROL, d);
      for (i = 0; i < 8; i++) begin
         wr_reg(tmcs_pkg::ADDR_CONTROL, 8'(i));
         chk(16'({casc, pwm8, divm}), 16'(exp_dec(3'(i))));
      end
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h03);
      for (i = 4; i < 8; i++) begin
         wr_reg(tmcs_pkg::ADDR_SECOND, 8'(i));
         chk(16'(sdec), 16'(4'h1 << (i - 4)));
      end
      // cascade run, preset and upper-byte clock.
      wr_reg(tmcs_pkg::ADDR_SECOND, 8'h8C);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(16'({run3, pre3, run4, pre4, clr4}), 16'h001E);
      rd_chk(tmcs_pkg::ADDR_STATUS, 8'h13);
      @(posedge clk_sys);
      ovf3 <= 1'h1;
      @(posedge clk_sys);
      ovf3 <= 1'h0;
      #1;
      chk(16'(tick4), 16'h0001);
      wr_reg(tmcs_pkg::ADDR_SECOND, 8'h84);
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h00);
      // every source select, then the divider select case.
      for (i = 0; i < 9; i++) begin
         @(posedge clk_sys);
         div_sel <= (i == 8);
         wr_reg(tmcs_pkg::ADDR_CONTROL, {1'h0, 3'(i), 4'h8});
         repeat (2) @(posedge clk_sys);
         #1;
         chk(16'({run3, clr3}), 16'h0002);
         meas(exp_per(3'(i), i == 8));
         wr_reg(tmcs_pkg::ADDR_CONTROL, {1'h0, 3'(i), 4'h0});
         repeat (2) @(posedge clk_sys);
         #1;
         chk(16'({run3, clr3}), 16'h0001);
      end
      @(posedge clk_sys);
      div_sel <= 1'h0;
      power_mode <= 2'h2;
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h38);
      chk(16'(bad), 16'h0001);
      n = 0;
      repeat (100) begin
         @(negedge clk_sys);
         n += (tick3 === 1'h1);
      end
      chk(16'(n), 16'h0000);
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h30);
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h08);
      meas(80);
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h00);
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h60);
      chk(16'(bad), 16'h0001);
      wr_reg(tmcs_pkg::ADDR_CONTROL, 8'h63);
      wr_reg(tmcs_pkg::ADDR_SECOND, 8'h05);
      chk(16'(bad), 16'h0000);
      wrap_up();
   end
endmodule // tb_timer3_control_and_clock_select
